// file: ir_front_model.sv
// infrared front-end model: drives the demodulated remote line
// assumes its tasks are called right after a rising clock edge
`default_nettype none
module ir_front_model (
  // clock
  input wire logic clk_i,
  // remote line, idle low
  output logic rx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rx_o = 1'h0;
  // ----
  // frames
  // ----
  // bit b: first half ~b, second half b, so each bit has a mid edge;
  // the last level is held so the end gap carries no stray edge
  task automatic send(input logic [15:0] bits, input int n, input int len,
                      input int tail);
    for (int i = 0; i < n; i++) begin
      rx_o <= ~bits[i];
      repeat (len) @(posedge clk_i);
      rx_o <= bits[i];
      repeat (len) @(posedge clk_i);
    end
    repeat (tail) @(posedge clk_i);
    rx_o <= 1'h0;
  endtask
  // guide pulse or glitch, rising edge to rising edge
  task automatic pulse(input int hi, input int lo, input int hi2);
    rx_o <= 1'h1;
    repeat (hi) @(posedge clk_i);
    rx_o <= 1'h0;
    repeat (lo) @(posedge clk_i);
    if (hi2 > 0) begin
      rx_o <= 1'h1;
      repeat (hi2) @(posedge clk_i);
      rx_o <= 1'h0;
    end
  endtask
endmodule
`default_nettype wire

// file: ir_manchester_rx.sv
// manchester remote-control receiver, guideless and guided formats,
// with an axi4-lite register slave. assumes rx_i comes from an ir front
// end, asynchronous to clk_sys_i; one write and one read at a time.
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`default_nettype none
module ir_manchester_rx
  import ir_rx_pkg::*;
#(
  parameter int CNT_W = 7
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // remote input
  input wire logic rx_i,
  // axi4-lite write
  input wire logic [7:0] s_awaddr_i,
  input wire logic s_awvalid_i,
  output logic s_awready_o,
  input wire logic [31:0] s_wdata_i,
  input wire logic [3:0] s_wstrb_i,
  input wire logic s_wvalid_i,
  output logic s_wready_o,
  output logic [1:0] s_bresp_o,
  output logic s_bvalid_o,
  input wire logic s_bready_i,
  // axi4-lite read
  input wire logic [7:0] s_araddr_i,
  input wire logic s_arvalid_i,
  output logic s_arready_o,
  output logic [31:0] s_rdata_o,
  output logic [1:0] s_rresp_o,
  output logic s_rvalid_o,
  input wire logic s_rready_i
);
  // ----------------------------------------------------------------
  // registers and bus slave
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q, timing_q, guide_q;
  logic aw_q, w_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  flag_s flag_q;
  logic [7:0] shift_q, data_q;
  logic [3:0] bct_q;
  cfg_s cfg;

  assign cfg.enable = ctrl_q[CTRL_EN_BIT];
  assign cfg.fmt = fmt_e'(ctrl_q[CTRL_FMT_BIT]);
  assign cfg.msb_first = ctrl_q[CTRL_DIR_BIT];
  assign cfg.invert = ctrl_q[CTRL_INV_BIT];
  assign cfg.div_sel = ctrl_q[CTRL_DIV_LSB +: 8];
  assign cfg.pre_sel = ctrl_q[CTRL_PRE_LSB +: 8];
  assign cfg.t1 = timing_q[T1_LSB +: FIELD_W];
  assign cfg.t2 = timing_q[T2_LSB +: FIELD_W];
  assign cfg.t3 = timing_q[T3_LSB +: FIELD_W];
  assign cfg.t4 = timing_q[T4_LSB +: FIELD_W];
  assign cfg.guide_lo = guide_q[GL_LSB +: FIELD_W];
  assign cfg.guide_hi = guide_q[GH_LSB +: FIELD_W];

  wire aw_take = s_awvalid_i && !aw_q && !s_bvalid_o;
  wire w_take = s_wvalid_i && !w_q && !s_bvalid_o;
  wire wr_go = aw_q && w_q;
  wire [7:0] wa = awaddr_q & ADDR_MASK;
  wire wr_ok = (wa == CTRL_OFS) || (wa == TIMING_OFS) || (wa == GUIDE_OFS)
    || (wa == STATUS_OFS) || (wa == SHIFT_OFS) || (wa == DATA_OFS);
  wire ar_take = s_arvalid_i && !s_rvalid_o;
  wire [7:0] ra = s_araddr_i & ADDR_MASK;
  wire rd_shift = ar_take && (ra == SHIFT_OFS);
  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}},
    {8{wstrb_q[0]}}};
  wire st_wr = wr_go && (wa == STATUS_OFS);
  // status flags except hold clear by writing one; hold clears on a shift read
  wire [31:0] st_clr = st_wr ? (wdata_q & wmask) : 32'h0000_0000;
  wire [31:0] status_word = {16'h0000, 4'h0, bct_q, 3'h0, flag_q.guide_ok,
    flag_q.hold, flag_q.rx_end, flag_q.data_error, flag_q.shift_full};
  logic [31:0] rd_mux;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    case (ra)
      CTRL_OFS: rd_mux = ctrl_q;
      TIMING_OFS: rd_mux = timing_q;
      GUIDE_OFS: rd_mux = guide_q;
      STATUS_OFS: rd_mux = status_word;
      SHIFT_OFS: rd_mux = {24'h000000, shift_q};
      DATA_OFS: rd_mux = {24'h000000, data_q};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  assign s_awready_o = !aw_q && !s_bvalid_o;
  assign s_wready_o = !w_q && !s_bvalid_o;
  assign s_arready_o = !s_rvalid_o;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_bvalid_o <= 1'b0;
      s_bresp_o <= RESP_OKAY;
      s_rvalid_o <= 1'b0;
      s_rresp_o <= RESP_OKAY;
      s_rdata_o <= 32'h0000_0000;
      ctrl_q <= CTRL_RST;
      timing_q <= TIMING_RST;
      guide_q <= GUIDE_RST;
    end else begin
      if (aw_take) begin
        aw_q <= 1'b1;
        awaddr_q <= s_awaddr_i;
      end
      if (w_take) begin
        w_q <= 1'b1;
        wdata_q <= s_wdata_i;
        wstrb_q <= s_wstrb_i;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_bvalid_o <= 1'b1;
        s_bresp_o <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        if (wa == CTRL_OFS) ctrl_q <= (ctrl_q & ~wmask) | (wdata_q & wmask);
        if (wa == TIMING_OFS) begin
          timing_q <= (timing_q & ~wmask) | (wdata_q & wmask);
        end
        if (wa == GUIDE_OFS) begin
          guide_q <= (guide_q & ~wmask) | (wdata_q & wmask);
        end
      end else if (s_bvalid_o && s_bready_i) begin
        s_bvalid_o <= 1'b0;
      end
      if (ar_take) begin
        s_rvalid_o <= 1'b1;
        s_rdata_o <= rd_mux;
        s_rresp_o <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_rvalid_o && s_rready_i) begin
        s_rvalid_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // input synchroniser and edge detect
  // ----------------------------------------------------------------
  logic sync1_q, sync2_q, prev_q;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      sync1_q <= rx_i;
      sync2_q <= sync1_q;
      prev_q <= sync2_q ^ cfg.invert;
    end
  end
  wire rx_lvl = sync2_q ^ cfg.invert;
  wire edge_any = rx_lvl ^ prev_q;
  wire edge_rise = rx_lvl && !prev_q;

  // ----------------------------------------------------------------
  // time base and pulse-width counter
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_GUIDE, S_SYNC, S_WAIT_T1, S_WAIT_T2, S_WAIT_T3,
    S_MID_EDGE, S_END_EDGE, S_HOLD
  } st_e;
  st_e st_q, st_d;
  logic half_q;
  logic [CNT_W-1:0] pw_q;
  logic tick;

  ir_time_base #(
    .SEL_W(8)
  ) u_tb (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .run_i(cfg.enable && (st_q != S_IDLE) && (st_q != S_HOLD)),
    .half_i(half_q),
    .div_sel_i(cfg.div_sel),
    .pre_sel_i(cfg.pre_sel),
    .tick_o(tick)
  );

  // timing n falls when the count reaches field plus one periods
  wire [CNT_W-1:0] pw_nx = pw_q + (tick ? 1'b1 : 1'b0);
  wire at_t1 = tick && (pw_nx == CNT_W'(cfg.t1) + 1'b1);
  wire at_t2 = tick && (pw_nx == CNT_W'(cfg.t2) + 1'b1);
  wire at_t3 = tick && (pw_nx == CNT_W'(cfg.t3) + 1'b1);
  wire at_t4 = tick && (pw_nx == CNT_W'(cfg.t4) + 1'b1);
  wire g_ok = (pw_q >= CNT_W'(cfg.guide_lo) + 1'b1)
    && (pw_q < CNT_W'(cfg.guide_hi) + 1'b1);

  // ----------------------------------------------------------------
  // bit decoder
  // ----------------------------------------------------------------
  logic s1_q, s3_q, first_q;
  logic [1:0] nbit_q;
  wire guided = (cfg.fmt == FMT_GUIDED);
  // manchester: 1 is low then high, 0 is high then low; a guideless first
  // bit has no earlier half so only a high first sample is acceptable
  wire bit_err = first_q ? !s1_q : (s1_q == s3_q);
  wire bit_val = s1_q;
  wire decide = (st_q == S_WAIT_T2) && at_t2;
  wire good_bit = decide && !bit_err;
  wire bad_bit = decide && bit_err;
  wire frame_start = cfg.enable && (st_q == S_IDLE) && edge_rise;
  wire guide_pass = (st_q == S_GUIDE) && edge_rise && g_ok;
  wire [7:0] shifted = cfg.msb_first ? {shift_q[6:0], bit_val}
    : {bit_val, shift_q[7:1]};
  wire byte_done = good_bit && (bct_q[2:0] == 3'h7);
  wire rate_flip = good_bit && guided
    && (half_q || (nbit_q == 2'(NORMAL_BITS_BEFORE_WIDE)));
  wire rx_end_ev = (st_q == S_END_EDGE) && at_t4;

  always_comb begin
    st_d = st_q;
    case (st_q)
      S_IDLE: if (frame_start) st_d = guided ? S_GUIDE : S_WAIT_T1;
      S_GUIDE: if (edge_rise) st_d = g_ok ? S_SYNC : S_GUIDE;
      S_SYNC: if (at_t1) st_d = S_MID_EDGE;
      S_WAIT_T1: if (at_t1) st_d = S_WAIT_T2;
      S_WAIT_T2: if (decide) st_d = bit_err ? S_IDLE
        : (rate_flip ? S_SYNC : S_WAIT_T3);
      S_WAIT_T3: if (at_t3) st_d = S_END_EDGE;
      S_MID_EDGE: begin
        if (edge_any) st_d = S_WAIT_T1;
        else if (at_t3) st_d = S_IDLE;
      end
      S_END_EDGE: begin
        if (edge_any) st_d = S_WAIT_T1;
        else if (at_t4) st_d = S_HOLD;
      end
      S_HOLD: if (rd_shift) st_d = S_IDLE;
      default: st_d = S_IDLE;
    endcase
    if (!cfg.enable) st_d = S_IDLE;
  end

  wire pw_clr = frame_start || ((st_q == S_GUIDE) && edge_rise) || rate_flip
    || ((st_q == S_MID_EDGE) && edge_any)
    || ((st_q == S_END_EDGE) && edge_any);
  wire clr_rx = (frame_start && !guided) || guide_pass;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= S_IDLE;
      pw_q <= '0;
      s1_q <= 1'b0;
      s3_q <= 1'b0;
      first_q <= 1'b0;
      nbit_q <= 2'h0;
      half_q <= 1'b0;
      shift_q <= 8'h00;
      data_q <= 8'h00;
      bct_q <= 4'h0;
      flag_q <= '0;
    end else begin
      st_q <= st_d;
      // counter saturates so a stalled line cannot wrap into a timing
      if (pw_clr) pw_q <= '0;
      else if (tick && !(&pw_q)) pw_q <= pw_nx;
      if (st_q == S_WAIT_T1 && at_t1) s1_q <= rx_lvl;
      if (st_q == S_WAIT_T3 && at_t3) s3_q <= rx_lvl;
      if (st_q == S_SYNC && at_t1) s3_q <= rx_lvl;
      if (clr_rx) begin
        shift_q <= 8'h00;
        bct_q <= 4'h0;
        first_q <= !guided;
        nbit_q <= 2'h0;
        half_q <= 1'b0;
      end else if (good_bit) begin
        first_q <= 1'b0;
        bct_q <= bct_q + 1'b1;
        shift_q <= byte_done ? 8'h00 : shifted;
        if (byte_done) data_q <= shifted;
        if (guided && half_q) begin
          half_q <= 1'b0;
        end else if (guided && nbit_q == 2'(NORMAL_BITS_BEFORE_WIDE)) begin
          half_q <= 1'b1;
          nbit_q <= 2'h0;
        end else if (guided && bct_q < 4'(NORMAL_BITS_BEFORE_WIDE + 1)) begin
          nbit_q <= nbit_q + 1'b1;
        end
      end else if (bad_bit) begin
        half_q <= 1'b0;
      end
      if (!cfg.enable) half_q <= 1'b0;
      // hardware set wins over a software clear in the same cycle
      flag_q.shift_full <= byte_done || (flag_q.shift_full && !st_clr[ST_FULL]);
      flag_q.data_error <= bad_bit
        || ((st_q == S_MID_EDGE) && !edge_any && at_t3)
        || (flag_q.data_error && !st_clr[ST_DERR]);
      flag_q.rx_end <= rx_end_ev || (flag_q.rx_end && !st_clr[ST_REND]);
      flag_q.hold <= rx_end_ev || (flag_q.hold && !rd_shift);
      flag_q.guide_ok <= guide_pass || (flag_q.guide_ok && !st_clr[ST_GOK]);
    end
  end
endmodule
`default_nettype wire

// file: ir_rx_pkg.sv
// package for the manchester remote-control receiver: map, fields, timing
// assumes a 32-bit axi4-lite slave and one 250 MHz system clock
`default_nettype none
package ir_rx_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TIMING_OFS = 8'h04;
  localparam logic [7:0] GUIDE_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  localparam logic [7:0] SHIFT_OFS = 8'h10;
  localparam logic [7:0] DATA_OFS = 8'h14;
  localparam logic [7:0] ADDR_MASK = 8'hFC;

  // ----------------------------------------------------------------
  // field layouts
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_FMT_BIT = 1;
  localparam int CTRL_DIR_BIT = 2;
  localparam int CTRL_INV_BIT = 3;
  localparam int CTRL_DIV_LSB = 8;
  localparam int CTRL_PRE_LSB = 16;
  localparam int FIELD_W = 5;
  localparam int T1_LSB = 0;
  localparam int T2_LSB = 8;
  localparam int T3_LSB = 16;
  localparam int T4_LSB = 24;
  localparam int GL_LSB = 0;
  localparam int GH_LSB = 8;
  localparam int ST_FULL = 0;
  localparam int ST_DERR = 1;
  localparam int ST_REND = 2;
  localparam int ST_HOLD = 3;
  localparam int ST_GOK = 4;
  localparam int ST_BCT_LSB = 8;
  localparam int NORMAL_BITS_BEFORE_WIDE = 3;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] TIMING_RST = 32'h1F17_0F07;
  localparam logic [31:0] GUIDE_RST = 32'h0000_0F07;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {FMT_GUIDELESS, FMT_GUIDED} fmt_e;

  typedef struct packed {
    logic enable;
    fmt_e fmt;
    logic msb_first;
    logic invert;
    logic [7:0] div_sel;
    logic [7:0] pre_sel;
    logic [FIELD_W-1:0] t1;
    logic [FIELD_W-1:0] t2;
    logic [FIELD_W-1:0] t3;
    logic [FIELD_W-1:0] t4;
    logic [FIELD_W-1:0] guide_lo;
    logic [FIELD_W-1:0] guide_hi;
  } cfg_s;

  typedef struct packed {
    logic shift_full;
    logic data_error;
    logic rx_end;
    logic hold;
    logic guide_ok;
  } flag_s;
endpackage
`default_nettype wire

// file: ir_rx_sva.sv
// checker for the register bus of the manchester receiver
// assumes it is bound to ir_manchester_rx and sees only its ports
`default_nettype none
module ir_rx_sva
  import ir_rx_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // write side
  input wire logic s_awvalid_i,
  input wire logic s_awready_o,
  input wire logic s_wvalid_i,
  input wire logic s_wready_o,
  input wire logic [1:0] s_bresp_o,
  input wire logic s_bvalid_o,
  input wire logic s_bready_i,
  // read side
  input wire logic [7:0] s_araddr_i,
  input wire logic s_arvalid_i,
  input wire logic s_arready_o,
  input wire logic [31:0] s_rdata_o,
  input wire logic [1:0] s_rresp_o,
  input wire logic s_rvalid_o,
  input wire logic s_rready_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  wire logic ar_take = s_arvalid_i && s_arready_o;
  wire logic unmapped = (s_araddr_i & ADDR_MASK) > DATA_OFS;
  // ----
  // assertions
  // ----
  chk_write_blocked: assert property (
    s_bvalid_o |-> !s_awready_o && !s_wready_o)
    else $error("write taken while response pending");
  chk_b_stands: assert property (
    s_bvalid_o && !s_bready_i |=> s_bvalid_o && $stable(s_bresp_o))
    else $error("write response dropped early");
  chk_b_answer: assert property (
    s_awvalid_i && s_awready_o && s_wvalid_i && s_wready_o
    |-> ##[1:2] s_bvalid_o)
    else $error("write response late");
  chk_b_release: assert property (
    s_bvalid_o && s_bready_i |=> !s_bvalid_o)
    else $error("write response held after handshake");
  chk_ar_blocked: assert property (s_arready_o == !s_rvalid_o)
    else $error("read address ready wrong");
  chk_r_answer: assert property (ar_take |=> s_rvalid_o)
    else $error("read data late");
  chk_r_stands: assert property (
    s_rvalid_o && !s_rready_i |=> s_rvalid_o && $stable(s_rdata_o))
    else $error("read data changed while waiting");
  chk_r_unmapped: assert property (
    ar_take && unmapped |=> s_rresp_o == RESP_SLVERR && s_rdata_o == '0)
    else $error("unmapped read not refused");
  // ----
  // coverage
  // ----
  cov_write: cover property (s_bvalid_o && s_bready_i);
  cov_refused: cover property (s_rvalid_o && s_rresp_o == RESP_SLVERR);
  cov_read: cover property (s_rvalid_o && s_rready_i);
endmodule
`default_nettype wire

// file: ir_time_base.sv
// time base: divider period times prescale count gives one tick pulse
// assumes select values are static while a frame is received
`default_nettype none
module ir_time_base
  import ir_rx_pkg::*;
#(
  parameter int SEL_W = 8
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // control
  input wire logic run_i,
  input wire logic half_i,
  input wire logic [SEL_W-1:0] div_sel_i,
  input wire logic [SEL_W-1:0] pre_sel_i,
  // tick
  output logic tick_o
);
  logic [SEL_W-1:0] div_q;
  logic [SEL_W-1:0] pre_q;
  logic slow_q;
  wire div_wrap = (div_q >= div_sel_i);
  wire pre_wrap = div_wrap && (pre_q >= pre_sel_i);

  // select value n means a period of n+1; the half-rate mode swallows
  // every second pre-tick rather than touching the counters
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_q <= '0;
      pre_q <= '0;
      slow_q <= 1'b0;
    end else if (!run_i) begin
      div_q <= '0;
      pre_q <= '0;
      slow_q <= 1'b0;
    end else begin
      div_q <= div_wrap ? '0 : div_q + 1'b1;
      if (div_wrap) begin
        pre_q <= pre_wrap ? '0 : pre_q + 1'b1;
      end
      if (pre_wrap) begin
        slow_q <= half_i ? !slow_q : 1'b0;
      end
    end
  end

  assign tick_o = pre_wrap && (!half_i || slow_q);
endmodule
`default_nettype wire

// file: testbench.sv
// self-checking bench for the manchester receiver
// assumes the front-end model owns rx and a 250 MHz clock
`default_nettype none
module testbench
  import ir_rx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [31:0] ctrl;
    logic [15:0] bits;
    int n;
    logic [31:0] data;
    logic [31:0] stat;
    logic [31:0] shf;
  } row_s;
  localparam int LIMIT = 20000;
  logic clk_sys_i, rst_b_i, rx_i;
  logic [7:0] s_awaddr_i, s_araddr_i;
  logic [31:0] s_wdata_i, s_rdata_o, rd_data;
  logic [3:0] s_wstrb_i;
  logic [1:0] s_bresp_o, s_rresp_o, rd_resp;
  logic s_awvalid_i, s_awready_o, s_wvalid_i, s_wready_o, s_bvalid_o;
  logic s_bready_i, s_arvalid_i, s_arready_o, s_rvalid_o, s_rready_i;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  row_s rows [3];

  ir_manchester_rx dut_u (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .rx_i(rx_i),
    .s_awaddr_i(s_awaddr_i), .s_awvalid_i(s_awvalid_i),
    .s_awready_o(s_awready_o), .s_wdata_i(s_wdata_i),
    .s_wstrb_i(s_wstrb_i), .s_wvalid_i(s_wvalid_i),
    .s_wready_o(s_wready_o), .s_bresp_o(s_bresp_o),
    .s_bvalid_o(s_bvalid_o), .s_bready_i(s_bready_i),
    .s_araddr_i(s_araddr_i), .s_arvalid_i(s_arvalid_i),
    .s_arready_o(s_arready_o), .s_rdata_o(s_rdata_o),
    .s_rresp_o(s_rresp_o), .s_rvalid_o(s_rvalid_o),
    .s_rready_i(s_rready_i)
  );
  ir_front_model fe_u (.clk_i(clk_sys_i), .rx_o(rx_i));

  initial begin
    clk_sys_i = 1'h0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  // a hang ends the run as a failure
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // ----
  // bus tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    s_awaddr_i <= a;
    s_wdata_i <= v;
    s_awvalid_i <= 1'h1;
    s_wvalid_i <= 1'h1;
    s_bready_i <= 1'h1;
    do begin
      @(posedge clk_sys_i);
      if (s_awvalid_i && s_awready_o) s_awvalid_i <= 1'h0;
      if (s_wvalid_i && s_wready_o) s_wvalid_i <= 1'h0;
    end while (s_bvalid_o !== 1'h1);
    s_bready_i <= 1'h0;
    chk("bresp", 32'h0, {30'h0, s_bresp_o});
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_i);
    s_araddr_i <= a;
    s_arvalid_i <= 1'h1;
    s_rready_i <= 1'h1;
    do begin
      @(posedge clk_sys_i);
      if (s_arvalid_i && s_arready_o) s_arvalid_i <= 1'h0;
    end while (s_rvalid_o !== 1'h1);
    s_rready_i <= 1'h0;
    rd_data = s_rdata_o;
    rd_resp = s_rresp_o;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(nm, e, rd_data & m);
  endtask
  // shift read releases the hold, then the sticky flags are cleared
  task automatic resume();
    rd(SHIFT_OFS);
    wr(STATUS_OFS, 32'h0000_0017);
    rchk("flags", STATUS_OFS, 32'h0000_001F, 32'h0);
  endtask
  task automatic print_verdict();
    $display("n_mismatch %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    {s_awaddr_i, s_araddr_i, s_wdata_i} = '0;
    {s_awvalid_i, s_wvalid_i, s_bready_i} = 3'h0;
    {s_arvalid_i, s_rready_i} = 2'h0;
    s_wstrb_i = 4'hF;
    rst_b_i = 1'h0;
    // bit vectors are in arrival order; a guideless frame opens with a 1
    rows[0] = '{32'h0000_0101, 16'h0BA5, 12, 32'h0000_00A5, 32'h0000_0C0D,
      32'h0000_00B0};
    rows[1] = '{32'h0000_0105, 16'h00CD, 8, 32'h0000_00B3, 32'h0000_080D,
      32'h0000_0000};
    rows[2] = '{32'h0000_0101, 16'h3CA5, 16, 32'h0000_003C, 32'h0000_000D,
      32'h0000_0000};
    repeat (2) @(posedge clk_sys_i);
    rst_b_i <= 1'h1;
    rchk("ctrl", CTRL_OFS, 32'hFFFF_FFFF, CTRL_RST);
    rchk("timing", TIMING_OFS, 32'hFFFF_FFFF, TIMING_RST);
    rchk("guide", GUIDE_OFS, 32'hFFFF_FFFF, GUIDE_RST);
    rchk("status", STATUS_OFS, 32'hFFFF_FFFF, 32'h0);
    rchk("unmapped data", 8'h18, 32'hFFFF_FFFF, 32'h0);
    chk("unmapped resp", 32'h2, {30'h0, rd_resp});
    // tick is two clocks; timings at 4, 8, 12 and 16 ticks
    wr(TIMING_OFS, 32'h0F0B_0703);
    wr(GUIDE_OFS, 32'h0000_0F07);
    foreach (rows[i]) begin
      wr(CTRL_OFS, rows[i].ctrl);
      fe_u.send(rows[i].bits, rows[i].n, 14, 80);
      rchk("frame status", STATUS_OFS, 32'h0000_0FFF, rows[i].stat);
      rchk("frame data", DATA_OFS, 32'h0000_00FF, rows[i].data);
      rchk("frame shift", SHIFT_OFS, 32'h0000_00FF, rows[i].shf);
      resume();
    end
    // start edge followed by low at timing one
    fe_u.pulse(3, 100, 0);
    rchk("first bit", STATUS_OFS, 32'h0000_001F, 32'h2);
    resume();
    wr(CTRL_OFS, 32'h0000_0103);
    // guide of 4 ticks lies below the low limit
    fe_u.pulse(4, 4, 200);
    rchk("short guide", STATUS_OFS, 32'h0000_001F, 32'h0);
    // valid guide of 12 ticks, then no edge before timing three
    fe_u.pulse(12, 12, 200);
    rchk("guide", STATUS_OFS, 32'h0000_001F, 32'h12);
    print_verdict();
  end
endmodule

bind ir_manchester_rx ir_rx_sva chk_u (
  .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
  .s_awvalid_i(s_awvalid_i), .s_awready_o(s_awready_o),
  .s_wvalid_i(s_wvalid_i), .s_wready_o(s_wready_o),
  .s_bresp_o(s_bresp_o), .s_bvalid_o(s_bvalid_o), .s_bready_i(s_bready_i),
  .s_araddr_i(s_araddr_i), .s_arvalid_i(s_arvalid_i),
  .s_arready_o(s_arready_o), .s_rdata_o(s_rdata_o), .s_rresp_o(s_rresp_o),
  .s_rvalid_o(s_rvalid_o), .s_rready_i(s_rready_i)
);
`default_nettype wire
